// [rtl/dspm_pkg.sv]
// Package: pin numbering, function selects, pull-up bits and carriers
//
// Contract
// - Index pin defaults to decoder index after reset
// - Port C bit 6 clear disables index pull-up
// - Home pin defaults to decoder home after reset
// - Port C bit 7 clear disables home pull-up
// - Clock pin defaults SPI; port E bit 4 pull-up
// - Master-out pin defaults SPI; port E bit 5 pull-up
// - Master-in pin defaults SPI; port E bit 6 pull-up
// - Port E bit 7 clear disables select pull-up
// - GPIO pins have individual direction control
// - Clock pin drives as master, input as slave
// - Master drives master-out, changes half-cycle early
// - Unselected slave keeps master-in released
// - Selected slave presents master-in half-cycle early
// - Slave-select input marks transfer addressed to device
package dspm_pkg;

  // Pin count and pin positions in the pin vectors
  localparam int unsigned NUM_PINS = 7;
  localparam int unsigned PIN_INDEX = 0;
  localparam int unsigned PIN_HOME = 1;
  localparam int unsigned PIN_SCLK = 2;
  localparam int unsigned PIN_MOUT = 3;
  localparam int unsigned PIN_MIN = 4;
  localparam int unsigned PIN_SSEL = 5;
  localparam int unsigned PIN_SPARE = 6;

  // Pull-up enable register bit positions
  localparam int unsigned PC_PU_INDEX_BIT = 6;
  localparam int unsigned PC_PU_HOME_BIT = 7;
  localparam int unsigned PE_PU_SCLK_BIT = 4;
  localparam int unsigned PE_PU_MOUT_BIT = 5;
  localparam int unsigned PE_PU_MIN_BIT = 6;
  localparam int unsigned PE_PU_SSEL_BIT = 7;

  // Pull-up register width and reset value (all enabled)
  localparam int unsigned PU_W = 8;
  localparam logic [7:0] PU_RESET = 8'hff;

  // Decoder pin function select
  typedef enum logic [1:0] {
    DSPM_QD_PERIPH = 2'h0,
    DSPM_QD_TIMER = 2'h1,
    DSPM_QD_GPIO = 2'h3
  } dspm_qd_fn_t;

  // SPI pin function select
  typedef enum logic {
    DSPM_SPI_PERIPH = 1'h0,
    DSPM_SPI_GPIO = 1'h1
  } dspm_spi_fn_t;

  // Per-pin software configuration
  typedef struct packed {
    dspm_qd_fn_t index_fn;
    dspm_qd_fn_t home_fn;
    dspm_spi_fn_t sclk_fn;
    dspm_spi_fn_t mout_fn;
    dspm_spi_fn_t min_fn;
    dspm_spi_fn_t ssel_fn;
  } dspm_sel_t;

  // One pin's core-side drive: data and active-high enable
  typedef struct packed {
    logic dat;
    logic en;
  } dspm_drv_t;

endpackage

// [rtl/dspm_sync.sv]
// Two-flop synchroniser bank for pad inputs
`timescale 1ns/10ps
`default_nettype none
module dspm_sync #(
  parameter int unsigned WIDTH = 7
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // First stage, read only by second stage
  logic [WIDTH-1:0] meta;

  ////////////////////////////////////////////////////////////////////////
  // One two-flop chain per bit
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta[g] <= 1'b1;
          sync_o[g] <= 1'b1;
        end else begin
          meta[g] <= async_i[g];
          sync_o[g] <= meta[g];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// [rtl/dspm_pin_mux.sv]
// Decoder and SPI pin multiplexer with pull-up control
`timescale 1ns/10ps
`default_nettype none
module dspm_pin_mux (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Software configuration
  input wire dspm_pkg::dspm_sel_t sel_i,
  input wire logic [7:0] port_c_pullup_enable_i,
  input wire logic [7:0] port_e_pullup_enable_i,
  input wire logic [dspm_pkg::NUM_PINS-1:0] gpio_dir_out_i,
  input wire logic [dspm_pkg::NUM_PINS-1:0] gpio_dat_i,
  input wire logic spi0_master_mode_i,
  // Timer A channel 2 and 3 drive from the timer
  input wire dspm_pkg::dspm_drv_t timer_a_channel_2_i,
  input wire dspm_pkg::dspm_drv_t timer_a_channel_3_i,
  // SPI engine side
  input wire logic spi0_clock_out_i,
  input wire logic spi0_master_out_i,
  input wire logic spi0_master_in_i,
  input wire logic spi0_slave_select_i,
  input wire logic spi0_shift_edge_i,
  // Pads: in, out, output enable (low drives)
  input wire logic [dspm_pkg::NUM_PINS-1:0] pad_in_i,
  output logic [dspm_pkg::NUM_PINS-1:0] pad_out_o,
  output logic [dspm_pkg::NUM_PINS-1:0] pad_oe_n_o,
  output logic [dspm_pkg::NUM_PINS-1:0] pad_pullup_o,
  // Peripheral side inputs
  output logic decoder0_index_in_o,
  output logic decoder0_home_in_o,
  output logic timer_a_channel_2_in_o,
  output logic timer_a_channel_3_in_o,
  output logic spi0_serial_clock_o,
  output logic spi0_master_out_o,
  output logic spi0_master_in_o,
  output logic spi0_slave_select_o,
  output logic spi0_selected_o,
  output logic [dspm_pkg::NUM_PINS-1:0] gpio_in_o
);

  // Synchronised pad levels
  logic [dspm_pkg::NUM_PINS-1:0] pad_s;
  // Core drive enable per pin, active high
  logic [dspm_pkg::NUM_PINS-1:0] next_drv_en;
  // Core drive data per pin
  logic [dspm_pkg::NUM_PINS-1:0] next_drv_dat;
  // Pull-up set gathered from both registers
  logic [dspm_pkg::NUM_PINS-1:0] next_pullup;
  // Master-out and master-in launch registers
  logic mout_q;
  logic sout_q;

  ////////////////////////////////////////////////////////////////////////
  // Pad input synchronisers
  dspm_sync #(
    .WIDTH(dspm_pkg::NUM_PINS)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(pad_in_i),
    .sync_o(pad_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // Data launched on the shift edge, half a clock ahead of the sample edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mout_q <= 1'b0;
      sout_q <= 1'b0;
    end else if (spi0_shift_edge_i) begin
      mout_q <= spi0_master_out_i;
      sout_q <= spi0_master_in_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Peripheral input routing
  always_comb begin
    decoder0_index_in_o = pad_s[dspm_pkg::PIN_INDEX];
    decoder0_home_in_o = pad_s[dspm_pkg::PIN_HOME];
    timer_a_channel_2_in_o = pad_s[dspm_pkg::PIN_INDEX];
    timer_a_channel_3_in_o = pad_s[dspm_pkg::PIN_HOME];
    spi0_serial_clock_o = pad_s[dspm_pkg::PIN_SCLK];
    spi0_master_out_o = pad_s[dspm_pkg::PIN_MOUT];
    spi0_master_in_o = pad_s[dspm_pkg::PIN_MIN];
    spi0_slave_select_o = pad_s[dspm_pkg::PIN_SSEL];
    // Active-low select seen only while the pin is in SPI use
    spi0_selected_o = (sel_i.ssel_fn == dspm_pkg::DSPM_SPI_PERIPH) &&
      !spi0_master_mode_i && !pad_s[dspm_pkg::PIN_SSEL];
    gpio_in_o = pad_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drive selection per pin
  always_comb begin
    next_drv_en = '0;
    next_drv_dat = '0;
    // Index pin
    unique case (sel_i.index_fn)
      dspm_pkg::DSPM_QD_TIMER: begin
        next_drv_en[dspm_pkg::PIN_INDEX] = timer_a_channel_2_i.en;
        next_drv_dat[dspm_pkg::PIN_INDEX] = timer_a_channel_2_i.dat;
      end
      dspm_pkg::DSPM_QD_GPIO: begin
        next_drv_en[dspm_pkg::PIN_INDEX] =
          gpio_dir_out_i[dspm_pkg::PIN_INDEX];
        next_drv_dat[dspm_pkg::PIN_INDEX] = gpio_dat_i[dspm_pkg::PIN_INDEX];
      end
      default: begin
        // Decoder input: pad released
        next_drv_en[dspm_pkg::PIN_INDEX] = 1'b0;
      end
    endcase
    // Home pin
    unique case (sel_i.home_fn)
      dspm_pkg::DSPM_QD_TIMER: begin
        next_drv_en[dspm_pkg::PIN_HOME] = timer_a_channel_3_i.en;
        next_drv_dat[dspm_pkg::PIN_HOME] = timer_a_channel_3_i.dat;
      end
      dspm_pkg::DSPM_QD_GPIO: begin
        next_drv_en[dspm_pkg::PIN_HOME] =
          gpio_dir_out_i[dspm_pkg::PIN_HOME];
        next_drv_dat[dspm_pkg::PIN_HOME] = gpio_dat_i[dspm_pkg::PIN_HOME];
      end
      default: begin
        // Decoder input: pad released
        next_drv_en[dspm_pkg::PIN_HOME] = 1'b0;
      end
    endcase
    // Serial clock: out as master, in as slave
    if (sel_i.sclk_fn == dspm_pkg::DSPM_SPI_PERIPH) begin
      next_drv_en[dspm_pkg::PIN_SCLK] = spi0_master_mode_i;
      next_drv_dat[dspm_pkg::PIN_SCLK] = spi0_clock_out_i;
    end else begin
      next_drv_en[dspm_pkg::PIN_SCLK] = gpio_dir_out_i[dspm_pkg::PIN_SCLK];
      next_drv_dat[dspm_pkg::PIN_SCLK] = gpio_dat_i[dspm_pkg::PIN_SCLK];
    end
    // Master-out: driven by master only
    if (sel_i.mout_fn == dspm_pkg::DSPM_SPI_PERIPH) begin
      next_drv_en[dspm_pkg::PIN_MOUT] = spi0_master_mode_i;
      next_drv_dat[dspm_pkg::PIN_MOUT] = mout_q;
    end else begin
      next_drv_en[dspm_pkg::PIN_MOUT] = gpio_dir_out_i[dspm_pkg::PIN_MOUT];
      next_drv_dat[dspm_pkg::PIN_MOUT] = gpio_dat_i[dspm_pkg::PIN_MOUT];
    end
    // Master-in: driven only by a selected slave
    if (sel_i.min_fn == dspm_pkg::DSPM_SPI_PERIPH) begin
      next_drv_en[dspm_pkg::PIN_MIN] = !spi0_master_mode_i &&
        !pad_s[dspm_pkg::PIN_SSEL] &&
        (sel_i.ssel_fn == dspm_pkg::DSPM_SPI_PERIPH);
      next_drv_dat[dspm_pkg::PIN_MIN] = sout_q;
    end else begin
      next_drv_en[dspm_pkg::PIN_MIN] = gpio_dir_out_i[dspm_pkg::PIN_MIN];
      next_drv_dat[dspm_pkg::PIN_MIN] = gpio_dat_i[dspm_pkg::PIN_MIN];
    end
    // Slave select: input only in SPI use
    if (sel_i.ssel_fn == dspm_pkg::DSPM_SPI_PERIPH) begin
      next_drv_en[dspm_pkg::PIN_SSEL] = 1'b0;
    end else begin
      next_drv_en[dspm_pkg::PIN_SSEL] = gpio_dir_out_i[dspm_pkg::PIN_SSEL];
      next_drv_dat[dspm_pkg::PIN_SSEL] = gpio_dat_i[dspm_pkg::PIN_SSEL];
    end
    // Spare position: plain GPIO
    next_drv_en[dspm_pkg::PIN_SPARE] = gpio_dir_out_i[dspm_pkg::PIN_SPARE];
    next_drv_dat[dspm_pkg::PIN_SPARE] = gpio_dat_i[dspm_pkg::PIN_SPARE];
  end

  ////////////////////////////////////////////////////////////////////////
  // Pull-up gathering from register bits
  always_comb begin
    next_pullup = '1;
    next_pullup[dspm_pkg::PIN_INDEX] =
      port_c_pullup_enable_i[dspm_pkg::PC_PU_INDEX_BIT];
    next_pullup[dspm_pkg::PIN_HOME] =
      port_c_pullup_enable_i[dspm_pkg::PC_PU_HOME_BIT];
    next_pullup[dspm_pkg::PIN_SCLK] =
      port_e_pullup_enable_i[dspm_pkg::PE_PU_SCLK_BIT];
    next_pullup[dspm_pkg::PIN_MOUT] =
      port_e_pullup_enable_i[dspm_pkg::PE_PU_MOUT_BIT];
    next_pullup[dspm_pkg::PIN_MIN] =
      port_e_pullup_enable_i[dspm_pkg::PE_PU_MIN_BIT];
    next_pullup[dspm_pkg::PIN_SSEL] =
      port_e_pullup_enable_i[dspm_pkg::PE_PU_SSEL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered pad drive; reset releases all pads with pull-ups on
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pad_oe_n_o <= '1;
      pad_out_o <= '0;
    end else begin
      pad_oe_n_o <= ~next_drv_en;
      pad_out_o <= next_drv_dat;
    end
  end

  // Registered pull-up controls
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pad_pullup_o <= '1;
    end else begin
      pad_pullup_o <= next_pullup;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_index_pullup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !port_c_pullup_enable_i[dspm_pkg::PC_PU_INDEX_BIT] |=>
    !pad_pullup_o[dspm_pkg::PIN_INDEX])
    else $error("index pull-up not off");
  a_home_pullup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !port_c_pullup_enable_i[dspm_pkg::PC_PU_HOME_BIT] |=>
    !pad_pullup_o[dspm_pkg::PIN_HOME])
    else $error("home pull-up not off");
  a_sclk_pullup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !port_e_pullup_enable_i[dspm_pkg::PE_PU_SCLK_BIT] |=>
    !pad_pullup_o[dspm_pkg::PIN_SCLK])
    else $error("clock pull-up not off");
  a_mout_pullup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !port_e_pullup_enable_i[dspm_pkg::PE_PU_MOUT_BIT] |=>
    !pad_pullup_o[dspm_pkg::PIN_MOUT])
    else $error("master-out pull-up not off");
  a_min_pullup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !port_e_pullup_enable_i[dspm_pkg::PE_PU_MIN_BIT] |=>
    !pad_pullup_o[dspm_pkg::PIN_MIN])
    else $error("master-in pull-up not off");
  a_ssel_pullup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !port_e_pullup_enable_i[dspm_pkg::PE_PU_SSEL_BIT] |=>
    !pad_pullup_o[dspm_pkg::PIN_SSEL])
    else $error("select pull-up not off");
  a_sclk_dir: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sel_i.sclk_fn == dspm_pkg::DSPM_SPI_PERIPH) |=>
    (pad_oe_n_o[dspm_pkg::PIN_SCLK] == !$past(spi0_master_mode_i)))
    else $error("clock pin direction wrong");
  a_min_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sel_i.min_fn == dspm_pkg::DSPM_SPI_PERIPH && pad_s[dspm_pkg::PIN_SSEL])
    |=> pad_oe_n_o[dspm_pkg::PIN_MIN])
    else $error("unselected slave drives master-in");
  a_mout_slave: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!spi0_master_mode_i && sel_i.mout_fn == dspm_pkg::DSPM_SPI_PERIPH) |=>
    pad_oe_n_o[dspm_pkg::PIN_MOUT])
    else $error("slave drives master-out");
  a_index_input: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sel_i.index_fn == dspm_pkg::DSPM_QD_PERIPH) |=>
    pad_oe_n_o[dspm_pkg::PIN_INDEX])
    else $error("index pin driven as decoder input");
  a_gpio_dir: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sel_i.home_fn == dspm_pkg::DSPM_QD_GPIO) |=>
    (pad_oe_n_o[dspm_pkg::PIN_HOME] ==
    !$past(gpio_dir_out_i[dspm_pkg::PIN_HOME])))
    else $error("gpio direction not applied");
  a_mout_launch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    spi0_shift_edge_i ##1 (spi0_master_mode_i && !spi0_shift_edge_i &&
    sel_i.mout_fn == dspm_pkg::DSPM_SPI_PERIPH) |=>
    (pad_out_o[dspm_pkg::PIN_MOUT] == $past(spi0_master_out_i, 2)))
    else $error("master-out data not launched");
  c_master: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    spi0_master_mode_i && !pad_oe_n_o[dspm_pkg::PIN_SCLK]);
  c_slave_sel: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    spi0_selected_o ##1 !pad_oe_n_o[dspm_pkg::PIN_MIN]);
  c_gpio_out: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    sel_i.index_fn == dspm_pkg::DSPM_QD_GPIO &&
    !pad_oe_n_o[dspm_pkg::PIN_INDEX]);

endmodule
`default_nettype wire

// [bench/dspm_peer_model.sv]
// External encoder and SPI peer model that resolves the seven pad wires
`timescale 1ns/10ps
`default_nettype none
module dspm_peer_model (
  input wire logic clk_i,
  input wire logic frame_i,
  input wire logic [6:0] ext_en_i,
  input wire logic [6:0] ext_dat_i,
  input wire logic [6:0] pad_out_i,
  input wire logic [6:0] pad_oe_n_i,
  input wire logic [6:0] pad_pullup_i,
  output logic [6:0] pad_in_o
);
  logic [6:0] last = '0; // Wire levels one cycle ago
  logic [6:0] drv_en; // Peer drive enables
  logic [6:0] drv_dat; // Peer drive levels
  logic sclk = 1'b0; // Peer serial clock
  ////////////////////////////////////////////////////////////////////
  // Within a frame the peer is the master: select low, clock running
  always_comb begin
    drv_en = ext_en_i;
    drv_dat = ext_dat_i;
    if (frame_i) begin
      drv_en[dspm_pkg::PIN_SSEL] = 1'b1;
      drv_dat[dspm_pkg::PIN_SSEL] = 1'b0;
      drv_en[dspm_pkg::PIN_SCLK] = 1'b1;
      drv_dat[dspm_pkg::PIN_SCLK] = sclk;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Device first, then peer, then pull-up; a floating wire wanders
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pad_in_o[i] = !pad_oe_n_i[i] ? pad_out_i[i] : drv_en[i] ? drv_dat[i]
        : pad_pullup_i[i] ? 1'b1 : ~last[i];
    end
  end
  // Clock stands still outside frames
  always_ff @(posedge clk_i) begin
    last <= pad_in_o;
    sclk <= frame_i ? ~sclk : 1'b0;
  end
endmodule
`default_nettype wire

// [bench/decoder_spi_pin_mux_tb_top.sv]
// Self-checking bench for the decoder and SPI pin multiplexer
`timescale 1ns/10ps
`default_nettype none
module decoder_spi_pin_mux_tb_top;
  // One ordinary case: inputs, then expected pad controls
  typedef struct {
    dspm_pkg::dspm_sel_t sel;
    logic [7:0] pc;
    logic [7:0] pe;
    logic [6:0] dir;
    logic [6:0] dat;
    logic master;
    logic [6:0] pu;
    logic [6:0] oe_n;
    logic [6:0] mask;
    logic [6:0] out;
  } dspm_row_t;
  localparam dspm_pkg::dspm_sel_t SEL_SPI = 8'h00; // Reset functions
  localparam dspm_pkg::dspm_sel_t SEL_GPIO = 8'hff; // All pins GPIO
  localparam dspm_pkg::dspm_sel_t SEL_TMR = 8'h50; // Timer on decoder
  logic clk_i, reset_n_i, master, frame, mout, min, shift;
  dspm_pkg::dspm_sel_t sel;
  dspm_pkg::dspm_drv_t t2, t3;
  logic [7:0] pc, pe;
  logic [6:0] dir, dat, ext_en, ext_dat, pad_in, pad_out, pad_oe_n;
  logic [6:0] pad_pu, gpio_in;
  logic idx, home, sclk_in, ssel_in, selected;
  logic t2_in, t3_in, mo_in, mi_in;
  int miscompares, n_compared, cycles;
  dspm_row_t rows[7];
  ////////////////////////////////////////////////////////////////////
  dspm_pin_mux uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sel_i(sel),
    .port_c_pullup_enable_i(pc), .port_e_pullup_enable_i(pe),
    .gpio_dir_out_i(dir), .gpio_dat_i(dat), .spi0_master_mode_i(master),
    .timer_a_channel_2_i(t2), .timer_a_channel_3_i(t3),
    .spi0_clock_out_i(1'b0), .spi0_master_out_i(mout),
    .spi0_master_in_i(min), .spi0_slave_select_i(1'b0),
    .spi0_shift_edge_i(shift), .pad_in_i(pad_in), .pad_out_o(pad_out),
    .pad_oe_n_o(pad_oe_n), .pad_pullup_o(pad_pu),
    .decoder0_index_in_o(idx), .decoder0_home_in_o(home),
    .timer_a_channel_2_in_o(t2_in), .timer_a_channel_3_in_o(t3_in),
    .spi0_serial_clock_o(sclk_in), .spi0_master_out_o(mo_in),
    .spi0_master_in_o(mi_in), .spi0_slave_select_o(ssel_in),
    .spi0_selected_o(selected), .gpio_in_o(gpio_in));
  dspm_peer_model peer (.clk_i(clk_i), .frame_i(frame), .ext_en_i(ext_en),
    .ext_dat_i(ext_dat), .pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n),
    .pad_pullup_i(pad_pu), .pad_in_o(pad_in));
  ////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      $display("ERROR at %0t: timeout", $time);
      report_and_stop();
    end
  end
  // Compare and count
  task automatic check(input logic [6:0] got, input logic [6:0] exp,
      input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_neg(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Launch three bits through the shift path and watch one pad
  task automatic shift_bits(input int pin);
    for (int k = 0; k < 3; k++) begin
      mout = k[0];
      min = k[0];
      shift = 1'b1;
      wait_neg(1);
      shift = 1'b0;
      wait_neg(1);
      check(7'(pad_out[pin]), 7'(k[0]), "shift data");
    end
  endtask
  // Print counts and verdict, then stop
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{SEL_SPI, 8'hff, 8'hff, 7'h00, 7'h00, 1'b1, 7'h7f, 7'h73,
      7'h00, 7'h00};
    rows[1] = '{SEL_SPI, 8'hbf, 8'hef, 7'h00, 7'h00, 1'b0, 7'h7a, 7'h7f,
      7'h00, 7'h00};
    rows[2] = '{SEL_SPI, 8'h7f, 8'hdf, 7'h00, 7'h00, 1'b1, 7'h75, 7'h73,
      7'h00, 7'h00};
    rows[3] = '{SEL_SPI, 8'hff, 8'h3f, 7'h00, 7'h00, 1'b1, 7'h4f, 7'h73,
      7'h00, 7'h00};
    rows[4] = '{SEL_GPIO, 8'hff, 8'hff, 7'h55, 7'h33, 1'b1, 7'h7f, 7'h2a,
      7'h7f, 7'h33};
    rows[5] = '{SEL_GPIO, 8'hff, 8'hff, 7'h2a, 7'h4c, 1'b0, 7'h7f, 7'h55,
      7'h7f, 7'h4c};
    rows[6] = '{SEL_TMR, 8'hff, 8'hff, 7'h00, 7'h00, 1'b0, 7'h7f, 7'h7e,
      7'h01, 7'h01};
    {master, frame, mout, min, shift} = '0;
    {sel, pc, pe, dir, dat, ext_en, ext_dat} = '0;
    t2 = '{dat: 1'b1, en: 1'b1};
    t3 = '{dat: 1'b1, en: 1'b0};
    reset_n_i = 1'b0;
    wait_neg(10);
    reset_n_i = 1'b1;
    // Ordinary cases from the table
    foreach (rows[k]) begin
      sel = rows[k].sel;
      pc = rows[k].pc;
      pe = rows[k].pe;
      dir = rows[k].dir;
      dat = rows[k].dat;
      master = rows[k].master;
      wait_neg(4);
      check(pad_pu, rows[k].pu, "pull-up");
      check(pad_oe_n, rows[k].oe_n, "drive");
      check(pad_out & rows[k].mask, rows[k].out, "pad data");
      if (rows[k].mask == 7'h7f) begin
        check(gpio_in, (dat & dir) | ~dir, "gpio in");
      end
    end
    // Reset in mid-run with every driver asked on, pull-ups off but the spare pin's
    {pc, pe, dir} = {8'h00, 8'h00, 7'h7f};
    sel = SEL_GPIO;
    wait_neg(3);
    reset_n_i = 1'b0;
    wait_neg(1);
    check(pad_pu, 7'h7f, "reset pull-up");
    check(pad_oe_n, 7'h7f, "reset drive");
    {sel, dir, pc, pe} = '0;
    {ext_en, ext_dat} = {7'h03, 7'h02};
    wait_neg(2);
    reset_n_i = 1'b1;
    wait_neg(4);
    check(7'({idx, home, t2_in, t3_in}), 7'h05, "decoder in");
    // Slave frame: select low turns the master-in driver on
    {ext_en, pe, master, frame} = {7'h00, 8'hff, 1'b0, 1'b1};
    wait_neg(4);
    check(7'({selected, ssel_in, mo_in, mi_in}), 7'h0a, "selected");
    check(7'(pad_oe_n[4]), 7'h0, "slave out drive");
    shift_bits(dspm_pkg::PIN_MIN);
    // Select pin as GPIO no longer selects
    sel = 8'h01;
    wait_neg(4);
    check(7'(selected), 7'h0, "gpio select");
    check(7'(pad_oe_n[4]), 7'h1, "released");
    // Master shifting on master-out
    {sel, frame, master} = {SEL_SPI, 1'b0, 1'b1};
    wait_neg(4);
    check(7'({sclk_in, pad_oe_n[2]}), 7'h00, "master clock");
    shift_bits(dspm_pkg::PIN_MOUT);
    report_and_stop();
  end
endmodule
`default_nettype wire
